/* File: rwu_pkg.sv */
/*
 * Shared constants of the reset and watchdog unit: register offsets, field
 * positions, reset values and cycle counts.
 * Assumes a 50 MHz core clock; the filter and stretch counts are derived from it here.
 */
package rwu_pkg;
	localparam int CLK_MHZ = 50;

	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CAUSE = 8'h00;
	localparam logic [7:0] OFS_WDCTL = 8'h04;
	localparam logic [7:0] OFS_MISC  = 8'h08;

	// reset cause register fields
	localparam int          CAUSE_W   = 5;
	localparam int          CB_POR    = 0;
	localparam int          CB_EXT    = 1;
	localparam int          CB_DROP   = 2;
	localparam int          CB_WD     = 3;
	localparam int          CB_TEST   = 4;
	localparam logic [4:0]  CAUSE_RST = 5'h01;

	// watchdog control register fields
	localparam int         WB_FLAG = 7;
	localparam int         WB_IE   = 6;
	localparam int         WB_P3   = 5;
	localparam int         WB_CE   = 4;
	localparam int         WB_RE   = 3;
	localparam logic [2:0] WD_CE_WINDOW = 3'h4;

	// misc register fields
	localparam int MB_COMPARATOR_BANDGAP_SELECT = 0;
	localparam int MB_CONV = 1;
	localparam int MB_BG   = 2;

	// pin and supply filters: least pulse lengths, rounded up to cycles
	localparam int         EXT_MIN_NS   = 2500;
	localparam logic [7:0] EXT_MIN_CYC  = 8'((EXT_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam int         DROP_MIN_NS  = 2000;
	localparam logic [7:0] DROP_MIN_CYC = 8'((DROP_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam logic [2:0] DROP_FUSE_OFF = 3'h7;

	// reset stretch periods
	localparam int          STRETCH_W        = 24;
	localparam int          STRETCH_SHORT_US = 4100;
	localparam int          STRETCH_LONG_US  = 65000;
	localparam int          STRETCH_SHORT_CYC = STRETCH_SHORT_US * CLK_MHZ;
	localparam int          STRETCH_LONG_CYC  = STRETCH_LONG_US * CLK_MHZ;
	localparam logic [23:0] STRETCH_MIN_CYC  = 24'h000001;

	// watchdog time base: 128 kHz oscillator cycles
	localparam int WD_OSC_KHZ  = 128;
	localparam int WD_BASE_CYC = 2048;
	localparam int WD_SEL_MAX  = 9;
	localparam int WD_CNT_W    = 21;
endpackage : rwu_pkg

/* File: rwu_wd_if.sv */
/*
 * Link between the watchdog control logic and its counter.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/100ps
interface rwu_wd_if;
	logic       tick;
	logic       restart;
	logic       clear;
	logic [3:0] sel;
	logic       expire;

	modport ctl (output tick, restart, clear, sel, input expire);
	modport cnt (input tick, restart, clear, sel, output expire);
endinterface : rwu_wd_if

/* File: rwu_wd_counter.sv */
/*
 * Watchdog counter: counts oscillator ticks and pulses expire at time-out.
 * Assumes tick is already a one-cycle pulse on the core clock.
 */
`timescale 1ns/100ps
module rwu_wd_counter
	import rwu_pkg::*;
#(
	parameter int CNT_W = WD_CNT_W
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	// control link
	rwu_wd_if.cnt    wd
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             expire;
	} rwu_wdc_t;

	if (CNT_W < WD_CNT_W) begin : g_bad_width
		$error("watchdog counter too narrow for longest time-out");
	end

	rwu_wdc_t         st_r;
	rwu_wdc_t         st_nxt;
	logic [CNT_W-1:0] limit;
	logic [3:0]       sel_c;

	// time-out is 2048 oscillator cycles shifted by the select code, capped at 9
	always_comb begin
		sel_c = (wd.sel > 4'(WD_SEL_MAX)) ? 4'(WD_SEL_MAX) : wd.sel;
		limit = CNT_W'(WD_BASE_CYC) << sel_c;
		st_nxt = st_r;
		st_nxt.expire = 1'b0;
		if (wd.clear || wd.restart) begin
			st_nxt.cnt = '0;
		end else if (wd.tick) begin
			if (st_r.cnt == limit - 1'b1) begin
				st_nxt.cnt = '0;
				st_nxt.expire = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= '0;
		end else if (i_clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign wd.expire = st_r.expire;
endmodule : rwu_wd_counter

/* File: rwu_reset_watchdog.sv */
/*
 * Reset control and watchdog unit: merges the reset sources, stretches the
 * core reset, keeps the reset cause flags and the watchdog control register,
 * reached over APB.
 * Assumes pins, supply comparators and the test chain are asynchronous; fuses
 * are static; restart and vector-taken strobes come from the core clock.
 */
`timescale 1ns/100ps
module rwu_reset_watchdog
	import rwu_pkg::*;
#(
	parameter int P_STRETCH_SHORT_CYC = STRETCH_SHORT_CYC,
	parameter int P_STRETCH_LONG_CYC  = STRETCH_LONG_CYC
) (
	// clock, reset, enable
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_clk_en,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// reset sources
	input  wire logic        i_power_ok,
	input  wire logic        i_rst_pin_n,
	input  wire logic        i_supply_low,
	input  wire logic        i_test_reset,
	input  wire logic        i_wd_osc,
	// fuses
	input  wire logic [2:0]  i_drop_trigger_select_fuse,
	input  wire logic [1:0]  i_startup_time_fuse,
	input  wire logic [3:0]  i_clock_source_fuse,
	input  wire logic        i_wd_always_on_fuse,
	// core side
	input  wire logic        i_wd_restart,
	input  wire logic        i_wd_vector_taken,
	output logic             o_io_init,
	output logic             o_core_reset_n,
	output logic             o_fetch_vector,
	output logic             o_wd_irq,
	output logic             o_bandgap_on
);
	if (P_STRETCH_SHORT_CYC < 1 || P_STRETCH_LONG_CYC < 1 ||
	    P_STRETCH_SHORT_CYC >= (1 << STRETCH_W) || P_STRETCH_LONG_CYC >= (1 << STRETCH_W))
	begin : g_bad_stretch
		$error("stretch counts must fit the stretch counter");
	end

	typedef struct packed {
		logic [1:0]           pwr_s;
		logic [1:0]           pin_s;
		logic [1:0]           low_s;
		logic [1:0]           tst_s;
		logic [1:0]           osc_s;
		logic                 osc_d;
		logic [7:0]           ext_cnt;
		logic                 ext_act;
		logic [7:0]           drop_cnt;
		logic                 drop_act;
		logic                 wd_pulse;
		logic [STRETCH_W-1:0] stretch;
		logic                 core_rst;
		logic                 fetch;
		logic [CAUSE_W-1:0]   cause;
		logic                 wd_flag;
		logic                 wd_ie;
		logic [2:0]           wd_ce_cnt;
		logic                 wd_re;
		logic [3:0]           wd_ps;
		logic                 comparator_bandgap_select;
		logic                 conv;
		logic [31:0]          prdata;
	} rwu_state_t;

	localparam rwu_state_t ST_RST = '{pwr_s: 2'h0, pin_s: 2'h3, core_rst: 1'b1,
		cause: CAUSE_RST, default: '0};

	rwu_state_t           st_r;
	rwu_state_t           st_nxt;
	rwu_wd_if             wdb ();
	logic                 req;
	logic                 drop_en;
	logic                 re_eff;
	logic                 ie_eff;
	logic                 apb_acc;
	logic                 apb_wr;
	logic                 mapped;
	logic                 ce_open;
	logic [7:0]           wd_d;
	logic [STRETCH_W-1:0] stretch_len;

	// watchdog counter
	rwu_wd_counter u_wd_counter (
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_clk_en   (i_clk_en),
		.wd         (wdb.cnt)
	);

	// links to the counter: oscillator edge, restart, clear during reset
	assign wdb.tick    = st_r.osc_s[1] & ~st_r.osc_d;
	assign wdb.restart = i_wd_restart;
	assign wdb.clear   = st_r.core_rst;
	assign wdb.sel     = st_r.wd_ps;

	// combined source request and effective watchdog mode
	assign drop_en = i_drop_trigger_select_fuse != DROP_FUSE_OFF;
	assign req     = ~st_r.pwr_s[1] | st_r.ext_act | st_r.drop_act
		| st_r.wd_pulse | st_r.tst_s[1];
	assign re_eff  = st_r.wd_re | i_wd_always_on_fuse | st_r.cause[CB_WD];
	assign ie_eff  = st_r.wd_ie & ~i_wd_always_on_fuse;

	// apb decode
	assign apb_acc = i_psel & i_penable;
	assign apb_wr  = apb_acc & i_pwrite;
	assign mapped  = (i_paddr == OFS_CAUSE) || (i_paddr == OFS_WDCTL) || (i_paddr == OFS_MISC);
	assign wd_d    = i_pwdata[7:0];
	assign ce_open = apb_wr && i_paddr == OFS_WDCTL && wd_d[WB_CE] && wd_d[WB_RE];

	// stretch length from start-up and clock source fuses
	always_comb begin
		unique case (i_startup_time_fuse)
			2'h0: stretch_len = STRETCH_MIN_CYC;
			2'h1: stretch_len = STRETCH_W'(P_STRETCH_SHORT_CYC);
			2'h2: stretch_len = STRETCH_W'(P_STRETCH_LONG_CYC);
			2'h3: stretch_len = (i_clock_source_fuse == 4'h0) ?
				STRETCH_W'(P_STRETCH_SHORT_CYC) : STRETCH_W'(P_STRETCH_LONG_CYC);
		endcase
	end

	// next state
	always_comb begin
		st_nxt = st_r;
		// synchronisers
		st_nxt.pwr_s = {st_r.pwr_s[0], i_power_ok};
		st_nxt.pin_s = {st_r.pin_s[0], i_rst_pin_n};
		st_nxt.low_s = {st_r.low_s[0], i_supply_low};
		st_nxt.tst_s = {st_r.tst_s[0], i_test_reset};
		st_nxt.osc_s = {st_r.osc_s[0], i_wd_osc};
		st_nxt.osc_d = st_r.osc_s[1];

		// external pin: low must outlast the least pulse width
		if (!st_r.pin_s[1]) begin
			if (st_r.ext_cnt != EXT_MIN_CYC) st_nxt.ext_cnt = st_r.ext_cnt + 1'b1;
			st_nxt.ext_act = st_r.ext_cnt == EXT_MIN_CYC;
		end else begin
			st_nxt.ext_cnt = '0;
			st_nxt.ext_act = 1'b0;
		end

		// supply drop: dips no longer than the least duration are ignored
		if (drop_en && st_r.low_s[1]) begin
			if (st_r.drop_cnt != DROP_MIN_CYC) st_nxt.drop_cnt = st_r.drop_cnt + 1'b1;
			st_nxt.drop_act = st_r.drop_cnt == DROP_MIN_CYC;
		end else begin
			st_nxt.drop_cnt = '0;
			st_nxt.drop_act = 1'b0;
		end

		// stretch: reload while any source requests, count down after
		st_nxt.wd_pulse = 1'b0;
		if (req) begin
			st_nxt.stretch = stretch_len;
		end else if (st_r.stretch != '0) begin
			st_nxt.stretch = st_r.stretch - 1'b1;
		end
		st_nxt.core_rst = req | (st_r.stretch != '0);
		st_nxt.fetch = st_r.core_rst & ~st_nxt.core_rst;

		// change window counts down to zero on its own
		if (st_r.wd_ce_cnt != '0) st_nxt.wd_ce_cnt = st_r.wd_ce_cnt - 1'b1;

		// apb read data captured in the setup cycle
		if (i_psel && !i_penable) begin
			st_nxt.prdata = '0;
			unique case (i_paddr)
				OFS_CAUSE: st_nxt.prdata[CAUSE_W-1:0] = st_r.cause;
				OFS_WDCTL: st_nxt.prdata[7:0] = {st_r.wd_flag, ie_eff, st_r.wd_ps[3],
					st_r.wd_ce_cnt != '0, re_eff, st_r.wd_ps[2:0]};
				OFS_MISC: st_nxt.prdata[2:0] = {o_bandgap_on, st_r.conv, st_r.comparator_bandgap_select};
				default: st_nxt.prdata = '0;
			endcase
		end

		// register writes
		if (apb_wr && i_paddr == OFS_CAUSE) begin
			st_nxt.cause = st_r.cause & i_pwdata[CAUSE_W-1:0];
		end
		if (apb_wr && i_paddr == OFS_MISC) begin
			st_nxt.comparator_bandgap_select = i_pwdata[MB_COMPARATOR_BANDGAP_SELECT];
			st_nxt.conv = i_pwdata[MB_CONV];
		end
		if (apb_wr && i_paddr == OFS_WDCTL) begin
			st_nxt.wd_ie = wd_d[WB_IE];
			if (wd_d[WB_FLAG]) st_nxt.wd_flag = 1'b0;
			if (ce_open) begin
				st_nxt.wd_ce_cnt = WD_CE_WINDOW;
				st_nxt.wd_re = 1'b1;
			end else if (st_r.wd_ce_cnt != '0 && !wd_d[WB_CE]) begin
				st_nxt.wd_re = wd_d[WB_RE];
				st_nxt.wd_ps = {wd_d[WB_P3], wd_d[2:0]};
				st_nxt.wd_ce_cnt = '0;
			end else begin
				st_nxt.wd_re = st_r.wd_re | wd_d[WB_RE];
			end
		end

		// interrupt vector entry: clear flag, combined mode drops to reset mode
		if (i_wd_vector_taken) begin
			st_nxt.wd_flag = 1'b0;
			if (re_eff) st_nxt.wd_ie = 1'b0;
		end

		// expiry: interrupt first, reset when flag still pending or no interrupt
		if (wdb.expire && !st_r.core_rst) begin
			if (ie_eff && !(re_eff && st_r.wd_flag)) st_nxt.wd_flag = 1'b1;
			if (re_eff && (!ie_eff || st_r.wd_flag)) st_nxt.wd_pulse = 1'b1;
		end

		// internal reset returns control registers to their initial values
		if (st_r.core_rst) begin
			st_nxt.wd_flag = 1'b0;
			st_nxt.wd_ie = 1'b0;
			st_nxt.wd_ce_cnt = '0;
			st_nxt.wd_re = 1'b0;
			st_nxt.wd_ps = '0;
			st_nxt.comparator_bandgap_select = 1'b0;
			st_nxt.conv = 1'b0;
		end

		// cause flags: setting wins over clearing, power-on clears the others
		if (!st_r.pwr_s[1]) st_nxt.cause = CAUSE_RST;
		if (st_r.ext_act) st_nxt.cause[CB_EXT] = 1'b1;
		if (st_r.drop_act) st_nxt.cause[CB_DROP] = 1'b1;
		if (st_r.wd_pulse) st_nxt.cause[CB_WD] = 1'b1;
		if (st_r.tst_s[1]) st_nxt.cause[CB_TEST] = 1'b1;
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= ST_RST;
		end else if (i_clk_en) begin
			st_r <= st_nxt;
		end
	end

	// outputs
	assign o_io_init = ~i_arst_n | ~i_power_ok | ~i_rst_pin_n | st_r.core_rst;
	assign o_core_reset_n = ~st_r.core_rst;
	assign o_fetch_vector = st_r.fetch;
	assign o_wd_irq       = st_r.wd_flag & st_r.wd_ie;
	assign o_bandgap_on   = drop_en | st_r.comparator_bandgap_select | st_r.conv;
	assign o_prdata       = st_r.prdata;
	assign o_pready       = 1'b1;
	assign o_pslverr      = apb_acc & ~mapped;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n || !i_clk_en);

	a_req_holds_reset:
		assert property (req |=> st_r.core_rst) else $error("request did not hold reset");
	a_stretch_ends:
		assert property (!req && st_r.stretch == 24'h000001 ##1 !req |=> !st_r.core_rst)
		else $error("reset not released after stretch");
	a_io_init_async:
		assert property (!i_power_ok || !i_rst_pin_n |-> o_io_init)
		else $error("io init missing while source active");
	a_wd_pulse_one:
		assert property (st_r.wd_pulse |=> !st_r.wd_pulse && st_r.core_rst)
		else $error("watchdog reset pulse not one cycle");
	a_ce_self_clear:
		assert property (ce_open ##1 (!apb_wr)[*4] |=> st_r.wd_ce_cnt == 3'h0)
		else $error("change enable did not clear after four cycles");
	a_fuse_forces:
		assert property (i_wd_always_on_fuse && wdb.expire && !st_r.core_rst |=>
			st_r.wd_pulse && $stable(st_r.wd_flag))
		else $error("always-on fuse did not force reset mode");
	a_cause_keeps:
		assert property (st_r.cause[CB_WD] && wdb.expire && !ie_eff && !st_r.core_rst
			|=> st_r.wd_pulse) else $error("cause flag did not keep reset enable");
	a_restart_clean:
		assert property (i_wd_restart |=> !wdb.expire) else $error("expiry after restart");
	a_expire_irq:
		assert property (wdb.expire && ie_eff && !re_eff && !st_r.core_rst |=>
			st_r.wd_flag && !st_r.wd_pulse) else $error("interrupt mode expiry lost");
	a_late_write_ignored:
		assert property (apb_wr && i_paddr == OFS_WDCTL && st_r.wd_ce_cnt == 3'h0 &&
			st_r.wd_re && !st_r.core_rst |=> st_r.wd_re)
		else $error("reset enable cleared outside window");
	a_fetch_once:
		assert property (st_r.fetch |-> !st_r.core_rst ##1 !st_r.fetch)
		else $error("fetch strobe not a single cycle after release");
	a_pin_filter:
		assert property (st_r.pin_s[1] |=> !st_r.ext_act)
		else $error("pin reset without low pin");
	a_drop_filter:
		assert property (!st_r.low_s[1] |=> !st_r.drop_act)
		else $error("drop reset without low supply");
	a_por_flag:
		assert property (!st_r.pwr_s[1] |=> st_r.cause[CB_POR])
		else $error("power-on flag not set");
	a_wd_cleared:
		assert property (st_r.core_rst |=> !wdb.expire && !o_wd_irq)
		else $error("watchdog still active in reset");

	c_wd_reset: cover property (st_r.wd_pulse ##1 st_r.core_rst);
	c_irq_mode: cover property (wdb.expire && ie_eff && !re_eff);
	c_fuse_reset: cover property (i_wd_always_on_fuse && st_r.wd_pulse);
	c_window_change: cover property (ce_open ##[1:3] (apb_wr && !wd_d[WB_CE]));
	c_release_fetch: cover property (st_r.core_rst ##1 st_r.fetch);
endmodule : rwu_reset_watchdog

/* File: rwu_core_model.sv */
/*
 * Processor core stand-in: restarts the watchdog and enters its vector.
 * Assumes the tasks are called just after a rising core clock edge.
 */
`timescale 1ns/100ps
module rwu_core_model (
	// clock and interrupt
	input  wire logic i_core_clk,
	input  wire logic i_wd_irq,
	// strobes to the unit
	output logic      o_wd_restart,
	output logic      o_wd_vector_taken
);
	// strobes idle low from time zero
	initial begin
		o_wd_restart      = 1'b0;
		o_wd_vector_taken = 1'b0;
	end

	// one-cycle restart instruction
	task kick;
		@(posedge i_core_clk) o_wd_restart <= 1'b1;
		@(posedge i_core_clk) o_wd_restart <= 1'b0;
	endtask : kick

	// vector is entered once the interrupt is pending, or after 100 cycles without it
	task take_vector(output logic ok);
		int k;
		k = 0;
		while (i_wd_irq !== 1'b1 && k < 100) begin
			@(negedge i_core_clk);
			k++;
		end
		ok = (i_wd_irq === 1'b1);
		@(posedge i_core_clk) o_wd_vector_taken <= 1'b1;
		@(posedge i_core_clk) o_wd_vector_taken <= 1'b0;
	endtask : take_vector
endmodule : rwu_core_model

/* File: testbench.sv */
/*
 * Self-checking bench of the reset and watchdog unit over APB.
 * Assumes shortened stretch counts and a sped-up watchdog oscillator.
 */
`timescale 1ns/100ps
module testbench
	import rwu_pkg::*;
;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wdat = 0, rdv;
	logic        erv, vok, cen = 1, wfuse = 0, pok = 1, pin_n = 1, slow = 0, trst = 0;
	logic [2:0]  dfuse = 3'h7;
	logic [1:0]  odiv = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, io_init, core_n, fetch, irq, bg, rstrt, vtk;
	int          failures = 0, num_checks = 0, n, i;
	logic [4:0]  exp_c [4] = '{5'h02, 5'h04, 5'h10, 5'h01};

	// 50 MHz core clock; oscillator runs at a quarter of it to keep time-outs short
	always #10 clk = ~clk;
	always @(posedge clk) odiv <= odiv + 2'h1;

	rwu_reset_watchdog #(.P_STRETCH_SHORT_CYC(20), .P_STRETCH_LONG_CYC(40)) rwu_reset_watchdog_i (
		.i_core_clk(clk), .i_arst_n(rst_n), .i_clk_en(cen),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_power_ok(pok), .i_rst_pin_n(pin_n), .i_supply_low(slow), .i_test_reset(trst),
		.i_wd_osc(odiv[1]), .i_drop_trigger_select_fuse(dfuse), .i_startup_time_fuse(2'h1),
		.i_clock_source_fuse(4'h0), .i_wd_always_on_fuse(wfuse),
		.i_wd_restart(rstrt), .i_wd_vector_taken(vtk),
		.o_io_init(io_init), .o_core_reset_n(core_n), .o_fetch_vector(fetch),
		.o_wd_irq(irq), .o_bandgap_on(bg));

	rwu_core_model core_i (.i_core_clk(clk), .i_wd_irq(irq), .o_wd_restart(rstrt),
		.o_wd_vector_taken(vtk));

	// verdict and end of run
	task test_done;
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// compare one value
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer, request left up for chaining
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk) pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdv = prdata;
		erv = pslverr;
		if (k >= 50) begin
			chk("pready", 1, 0);
			test_done();
		end
	endtask : apb

	// release the bus for c cycles
	task idle(input int c);
		psel <= 1'b0;
		pen  <= 1'b0;
		repeat (c) @(posedge clk);
	endtask : idle

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		idle(1);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		idle(1);
		chk(nm, e, rdv);
	endtask : rd

	// wait for irq (w=0) or core reset (w=1) to reach v
	task wait_for(input int w, input logic v, input int lim, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (((w == 1) ? core_n : irq) !== v && c < lim);
		if (c >= lim) begin
			chk("wait", 1, 0);
			test_done();
		end
		if (w == 1 && v) chk("fetch", 1, fetch);
		@(posedge clk);
	endtask : wait_for

	// drive one reset source for len cycles: pin, drop, test, power
	task hit(input int s, input int len, input logic rst);
		case (s)
			0: pin_n <= 1'b0;
			1: slow <= 1'b1;
			2: trst <= 1'b1;
			default: pok <= 1'b0;
		endcase
		@(negedge clk);
		if (s == 0 || s == 3) chk("io init", 1, io_init);
		repeat (len) @(negedge clk);
		chk("core held", !rst, core_n);
		@(posedge clk);
		pin_n <= 1'b1;
		slow  <= 1'b0;
		trst  <= 1'b0;
		pok   <= 1'b1;
		@(posedge clk);
	endtask : hit

	// cut a hang short
	initial begin
		#1900000;
		chk("run time", 0, 1);
		test_done();
	end

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wait_for(1, 1, 400, n);
		rd(OFS_CAUSE, 32'h01, "cause init");
		rd(OFS_WDCTL, 32'h00, "wdctl init");
		for (i = 0; i < 4; i++) begin
			wr(OFS_MISC, 32'(i));
			rd(OFS_MISC, 32'(i) | ((i != 0) ? 32'h4 : 32'h0), "misc");
			chk("bandgap", (i != 0), bg);
		end
		apb(1'b1, 8'h0c, 32'hffffffff);
		chk("slverr wr", 1, erv);
		idle(1);
		apb(1'b0, 8'h0c, 32'h0);
		chk("slverr rd", 1, erv);
		chk("unmapped", 0, rdv);
		idle(1);
		wr(OFS_CAUSE, 32'h0);
		rd(OFS_CAUSE, 32'h0, "cause clr");
		hit(1, 150, 1'b0);
		hit(0, 60, 1'b0);
		dfuse <= 3'h0;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wait_for(1, 1, 400, n);
		chk("bandgap fuse", 1, bg);
		hit(1, 60, 1'b0);
		// each source resets, flags its cause and stretches the release
		for (i = 0; i < 4; i++) begin
			wr(OFS_CAUSE, 32'h0);
			hit(i, 150, 1'b1);
			wait_for(1, 1, 400, n);
			chk("stretch", 1, n >= 20 && n <= 28);
			rd(OFS_CAUSE, 32'(exp_c[i]), "cause src");
		end
		// timed change sequence
		wr(OFS_WDCTL, 32'h18);
		// frozen clock enable must hold the change window open
		cen <= 1'b0;
		repeat (10) @(posedge clk);
		cen <= 1'b1;
		rd(OFS_WDCTL, 32'h18, "ce open");
		idle(6);
		rd(OFS_WDCTL, 32'h08, "ce closed");
		wr(OFS_WDCTL, 32'h07);
		rd(OFS_WDCTL, 32'h08, "no window");
		for (i = 9; i >= 0; i--) begin
			apb(1'b1, OFS_WDCTL, 32'h18);
			apb(1'b1, OFS_WDCTL, {26'h0, i[3], 2'h0, i[2:0]});
			idle(1);
			rd(OFS_WDCTL, {26'h0, i[3], 2'h0, i[2:0]}, "prescale");
		end
		// interrupt mode: restarts keep it quiet, then it expires
		wr(OFS_CAUSE, 32'h0);
		wr(OFS_WDCTL, 32'h40);
		for (i = 0; i < 3; i++) begin
			core_i.kick();
			repeat (5000) @(posedge clk);
			chk("no expiry", 0, irq);
		end
		core_i.kick();
		wait_for(0, 1, 9000, n);
		chk("timeout", 1, n > 8100 && n < 8300);
		rd(OFS_WDCTL, 32'hc0, "irq flag");
		chk("no reset", 1, core_n);
		core_i.take_vector(vok);
		chk("vector irq", 1, vok);
		idle(2);
		rd(OFS_WDCTL, 32'h40, "irq only");
		// combined mode: interrupt, vector, then reset
		wr(OFS_WDCTL, 32'h48);
		core_i.kick();
		wait_for(0, 1, 9000, n);
		core_i.take_vector(vok);
		chk("vector irq", 1, vok);
		idle(2);
		rd(OFS_WDCTL, 32'h08, "vector");
		wait_for(1, 0, 9000, n);
		wait_for(1, 1, 400, n);
		chk("wd stretch", 1, n >= 20 && n <= 28);
		rd(OFS_CAUSE, 32'h08, "wd cause");
		apb(1'b1, OFS_WDCTL, 32'h18);
		apb(1'b1, OFS_WDCTL, 32'h00);
		idle(1);
		rd(OFS_WDCTL, 32'h08, "re forced");
		wr(OFS_CAUSE, 32'h0);
		apb(1'b1, OFS_WDCTL, 32'h18);
		apb(1'b1, OFS_WDCTL, 32'h00);
		idle(1);
		rd(OFS_WDCTL, 32'h00, "re off");
		// always-on fuse: reset mode forced, interrupt enable masked
		wr(OFS_WDCTL, 32'h40);
		wfuse <= 1'b1;
		rd(OFS_WDCTL, 32'h08, "fuse forces");
		core_i.kick();
		wait_for(1, 0, 9000, n);
		chk("fuse irq", 0, irq);
		wait_for(1, 1, 400, n);
		rd(OFS_CAUSE, 32'h08, "fuse cause");
		test_done();
	end
endmodule : testbench
